// File: logic/fbp_flash_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_ctrl (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          sck_i,
  input  wire logic          cs_n_i,
  input  wire logic          si_i,
  input  wire logic          wp_n_i,
  input  wire logic          page_bin_i,
  input  wire logic [511:0]  prot_table_i,
  input  wire logic          buf_rd_sel_i,
  input  wire logic [9:0]    buf_rd_pos_i,
  output logic [7:0]         buf_rd_data_o,
  output logic               pgm_start_o,
  output logic [12:0]        pgm_page_o,
  output logic               pgm_buf_o,
  output logic               pgm_skip_o,
  output logic               busy_o,
  output logic               ready_busy_o,
  output logic               prot_enabled_o,
  output logic               prot_by_cmd_o,
  output logic               prot_by_pin_o,
  output logic               table_writable_o
);
  localparam int FILT_W = 4;
  localparam int TMR_W  = 13;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(fbp_pkg::WP_FILTER_CYC - 1);
  localparam logic [TMR_W-1:0]  EP_LAST   = TMR_W'(fbp_pkg::PAGE_EP_CYC - 1);

  logic [7:0] rx_byte;
  logic       rx_tgl;

  fbp_spi_rx u_rx (
    .sck_i      (sck_i),
    .cs_n_i     (cs_n_i),
    .si_i       (si_i),
    .byte_o     (rx_byte),
    .byte_tgl_o (rx_tgl)
  );

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic cs_s1, cs_s2, cs_s3, cs_q;
  logic tg_s1, tg_s2, tg_s3, tg_q;
  logic wp_s1, wp_s2, wp_s3, wp_q;
  logic next_cs_q, next_tg_q, next_wp_q, frame_end, byte_ev;

  always_comb begin
    next_cs_q = (cs_s2 == cs_s3) ? cs_s3 : cs_q;
    next_tg_q = (tg_s2 == tg_s3) ? tg_s3 : tg_q;
    next_wp_q = (wp_s2 == wp_s3) ? wp_s3 : wp_q;
    frame_end = next_cs_q && !cs_q;
    // Toggle falls back at deselect; stage two of select masks that edge
    byte_ev   = !cs_q && !cs_s2 && (next_tg_q != tg_q);
  end

  always_ff @(posedge clk_i) begin
    cs_s1 <= cs_n_i;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    tg_s1 <= rx_tgl;
    tg_s2 <= tg_s1;
    tg_s3 <= tg_s2;
    wp_s1 <= wp_n_i;
    wp_s2 <= wp_s1;
    wp_s3 <= wp_s2;
    if (rst_i) begin
      cs_q <= 1'b1;
      tg_q <= 1'b0;
      wp_q <= 1'b1;
    end else begin
      cs_q <= next_cs_q;
      tg_q <= next_tg_q;
      wp_q <= next_wp_q;
    end
  end

  // Write-protect noise filter
  logic              wp_filt;
  logic [FILT_W-1:0] filt_cnt;
  logic              next_wp_filt;
  logic [FILT_W-1:0] next_filt_cnt;

  always_comb begin
    next_wp_filt  = wp_filt;
    next_filt_cnt = '0;
    if (wp_q != wp_filt) begin
      if (filt_cnt == FILT_LAST) begin
        next_wp_filt = wp_q;
      end else begin
        next_filt_cnt = filt_cnt + FILT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_filt  <= 1'b1;
      filt_cnt <= '0;
    end else begin
      wp_filt  <= next_wp_filt;
      filt_cnt <= next_filt_cnt;
    end
  end

  // Command parser and buffers
  fbp_pkg::fbp_cmd_type          state, next_state;
  logic [2:0]                    idx, next_idx;
  logic [15:0]                   addr_hi, next_addr_hi;
  logic [fbp_pkg::PAGE_W-1:0]    page, next_page;
  logic [fbp_pkg::POS_W-1:0]     pos, next_pos;
  logic                          sel, next_sel;
  logic                          seq_en, next_seq_en;
  logic                          sw_en, next_sw_en;
  logic                          wr_en;
  logic [fbp_pkg::ADDR_W-1:0]    full_addr;
  logic [fbp_pkg::POS_W-1:0]     last_pos;
  logic                          busy, next_busy;
  logic [TMR_W-1:0]              tmr, next_tmr;
  logic                          next_start, next_skip;
  logic                          wp_active, prot_on, page_blocked;
  logic [7:0]                    buf_mem [2][fbp_pkg::BUF_DEPTH];

  function automatic logic sector_marked(input logic [511:0] tbl,
                                         input logic [fbp_pkg::PAGE_W-1:0] pg);
    logic [5:0] sec;
    logic [7:0] tb;
    sec = pg[fbp_pkg::PAGE_W-1:fbp_pkg::SECT_LSB];
    tb  = tbl[{sec, 3'h0} +: 8];
    // Sector zero splits into a small and a large part, two bits each
    if (sec == 6'h00) begin
      sector_marked = (pg < fbp_pkg::SUB0A_PAGES) ? &tb[fbp_pkg::SUB0A_HI -: 2]
                                                  : &tb[fbp_pkg::SUB0B_HI -: 2];
    end else begin
      sector_marked = (tb == fbp_pkg::TBL_PROT);
    end
  endfunction

  always_comb begin
    wp_active    = !wp_filt;
    prot_on      = sw_en || wp_active;
    page_blocked = prot_on && sector_marked(prot_table_i, page);
    full_addr    = {addr_hi, rx_byte};
    last_pos     = page_bin_i ? fbp_pkg::BIN_LAST_POS : fbp_pkg::STD_LAST_POS;
    next_state   = state;
    next_idx     = idx;
    next_addr_hi = addr_hi;
    next_page    = page;
    next_pos     = pos;
    next_sel     = sel;
    next_seq_en  = seq_en;
    next_sw_en   = sw_en;
    next_busy    = busy;
    next_tmr     = tmr;
    next_start   = 1'b0;
    next_skip    = 1'b0;
    wr_en        = 1'b0;
    if (busy) begin
      if (tmr == EP_LAST) begin
        next_busy = 1'b0;
      end else begin
        next_tmr = tmr + TMR_W'(1);
      end
    end
    if (cs_q) begin
      next_state = fbp_pkg::CMD_OPCODE;
      next_idx   = 3'h0;
    end else if (byte_ev) begin
      case (state)
        fbp_pkg::CMD_OPCODE: begin
          if (rx_byte == fbp_pkg::OPC_PGM_BUF1 || rx_byte == fbp_pkg::OPC_PGM_BUF2) begin
            next_state = fbp_pkg::CMD_ADDR;
            next_sel   = (rx_byte == fbp_pkg::OPC_PGM_BUF2);
          end else if (rx_byte == fbp_pkg::SEQ_BYTE0) begin
            next_state = fbp_pkg::CMD_SEQ;
            next_idx   = 3'h1;
          end else begin
            next_state = fbp_pkg::CMD_IGNORE;
          end
        end
        fbp_pkg::CMD_ADDR: begin
          next_addr_hi = full_addr[15:0];
          next_idx     = idx + 3'h1;
          if (idx[1:0] == fbp_pkg::ADDR_LAST_IDX) begin
            next_state = fbp_pkg::CMD_DATA;
            if (page_bin_i) begin
              next_page = full_addr[fbp_pkg::BIN_PAGE_LSB +: fbp_pkg::PAGE_W];
              next_pos  = {1'b0, full_addr[fbp_pkg::BIN_POS_W-1:0]};
            end else begin
              next_page = full_addr[fbp_pkg::STD_PAGE_LSB +: fbp_pkg::PAGE_W];
              next_pos  = full_addr[fbp_pkg::POS_W-1:0];
            end
          end
        end
        fbp_pkg::CMD_DATA: begin
          wr_en    = 1'b1;
          next_pos = (pos >= last_pos) ? '0 : pos + 10'h001;
        end
        fbp_pkg::CMD_SEQ: begin
          next_idx = idx + 3'h1;
          if (idx == 3'h1 && rx_byte != fbp_pkg::SEQ_BYTE1) begin
            next_state = fbp_pkg::CMD_IGNORE;
          end else if (idx == 3'h2 && rx_byte != fbp_pkg::SEQ_BYTE2) begin
            next_state = fbp_pkg::CMD_IGNORE;
          end else if (idx == fbp_pkg::SEQ_LAST_IDX) begin
            next_seq_en = (rx_byte == fbp_pkg::SEQ_ENABLE);
            if (rx_byte != fbp_pkg::SEQ_ENABLE && rx_byte != fbp_pkg::SEQ_DISABLE) begin
              next_state = fbp_pkg::CMD_IGNORE;
            end
          end else if (idx == fbp_pkg::SEQ_DONE_IDX) begin
            next_state = fbp_pkg::CMD_IGNORE;
          end
        end
        fbp_pkg::CMD_IGNORE: next_state = fbp_pkg::CMD_IGNORE;
        default:             next_state = fbp_pkg::CMD_IGNORE;
      endcase
    end
    if (frame_end) begin
      // A new program while one runs is dropped rather than queued
      if (state == fbp_pkg::CMD_DATA && !busy) begin
        if (page_blocked) begin
          next_skip = 1'b1;
        end else begin
          next_start = 1'b1;
          next_busy  = 1'b1;
          next_tmr   = '0;
        end
      end
      if (state == fbp_pkg::CMD_SEQ && idx == fbp_pkg::SEQ_DONE_IDX) begin
        if (seq_en) begin
          next_sw_en = 1'b1;
        end else if (!wp_active) begin
          next_sw_en = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= fbp_pkg::CMD_OPCODE;
      idx         <= 3'h0;
      addr_hi     <= 16'h0000;
      page        <= '0;
      pos         <= '0;
      sel         <= 1'b0;
      seq_en      <= 1'b0;
      sw_en       <= 1'b0;
      busy        <= 1'b0;
      tmr         <= '0;
      pgm_start_o <= 1'b0;
      pgm_skip_o  <= 1'b0;
      pgm_page_o  <= '0;
      pgm_buf_o   <= 1'b0;
    end else begin
      state       <= next_state;
      idx         <= next_idx;
      addr_hi     <= next_addr_hi;
      page        <= next_page;
      pos         <= next_pos;
      sel         <= next_sel;
      seq_en      <= next_seq_en;
      sw_en       <= next_sw_en;
      busy        <= next_busy;
      tmr         <= next_tmr;
      pgm_start_o <= next_start;
      pgm_skip_o  <= next_skip;
      if (next_start) begin
        pgm_page_o <= page;
        pgm_buf_o  <= sel;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      buf_mem[sel][pos] <= rx_byte;
    end
    buf_rd_data_o <= buf_mem[buf_rd_sel_i][buf_rd_pos_i];
  end

  always_comb begin
    busy_o           = busy;
    ready_busy_o     = !busy;
    prot_enabled_o   = prot_on;
    prot_by_cmd_o    = sw_en;
    prot_by_pin_o    = wp_active;
    table_writable_o = wp_filt;
  end

  logic [TMR_W-1:0] ast_busy_cnt, next_ast_busy_cnt;
  always_comb next_ast_busy_cnt = busy_o ? ast_busy_cnt + TMR_W'(1) : '0;
  always_ff @(posedge clk_i) ast_busy_cnt <= rst_i ? '0 : next_ast_busy_cnt;

  AST_OPC_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == fbp_pkg::CMD_OPCODE && byte_ev && !cs_q
     && rx_byte != fbp_pkg::OPC_PGM_BUF1 && rx_byte != fbp_pkg::OPC_PGM_BUF2)
    |=> state != fbp_pkg::CMD_ADDR)
    else $error("Address phase entered without a program opcode");
  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && pos == last_pos) |=> pos == '0)
    else $error("Buffer position did not wrap to zero");
  AST_START: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_end && state == fbp_pkg::CMD_DATA && !busy && !page_blocked)
    |=> pgm_start_o && busy_o && pgm_page_o == $past(page))
    else $error("Program did not start at deselect");
  AST_BUSY_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
    (pgm_start_o |-> (busy_o && !ready_busy_o)[*8])
    and (ast_busy_cnt <= TMR_W'(fbp_pkg::PAGE_EP_CYC)))
    else $error("Busy window wrong");
  AST_SW_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_end && state == fbp_pkg::CMD_SEQ && idx == fbp_pkg::SEQ_DONE_IDX && seq_en)
    |=> prot_by_cmd_o && prot_enabled_o)
    else $error("Enable sequence did not set protection");
  AST_DIS_IGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (sw_en && wp_active && frame_end) |=> sw_en)
    else $error("Disable acted while write-protect low");
  AST_WP_ON: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wp_s3)[*8] |-> prot_enabled_o && prot_by_pin_o && !table_writable_o)
    else $error("Pin did not enable protection in time");
  AST_WP_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (wp_s3 && !sw_en)[*8] |-> !prot_enabled_o)
    else $error("Protection held after pin release");
  AST_GLITCH: assert property (@(posedge clk_i) disable iff (rst_i)
    (wp_filt && $fell(wp_q)) ##1 !wp_q ##1 $rose(wp_q) |-> wp_filt)
    else $error("Two-cycle glitch reached protection");
  AST_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_end && state == fbp_pkg::CMD_DATA && !busy && page_blocked)
    |=> pgm_skip_o && !pgm_start_o && !busy_o)
    else $error("Protected page was programmed");
  AST_VOLATILE: assert property (@(posedge clk_i)
    $past(rst_i) |-> !prot_by_cmd_o)
    else $error("Software protection survived reset");

  COV_PGM: cover property (@(posedge clk_i) disable iff (rst_i) pgm_start_o);
  COV_SKIP: cover property (@(posedge clk_i) disable iff (rst_i) pgm_skip_o);
  COV_WRAP: cover property (@(posedge clk_i) disable iff (rst_i) wr_en && pos == last_pos);
  COV_HOLD: cover property (@(posedge clk_i) disable iff (rst_i) sw_en && $rose(wp_filt));
endmodule // fbp_flash_ctrl
`default_nettype wire

// File: logic/fbp_pkg.sv
// How it works
// - Opcode 82h loads buffer one, 85h buffer two; three address bytes follow.
// - 528-byte pages: one spare bit, 13 page bits, 10 buffer position bits.
// - 512-byte pages: two spare bits, 13 page bits, 9 buffer position bits.
// - Data bytes fill successive buffer positions, wrapping to zero past the end.
// - Chip select rising ends the command; page erased then programmed, self-timed.
// - Busy shows on status and on the ready/busy pin during that cycle.
// - Sequence 3Dh 2Ah 7Fh A9h then deselect enables software protection.
// - Sequence 3Dh 2Ah 7Fh 9Ah disables protection, ignored while write-protect low.
// - Active protection blocks program and erase of sectors marked in the table.
// - Status shows protection enabled and whether by command or by pin.
// - Write-protect pin floats high, leaving protection to the commands.
// - Software protection comes up disabled after power-up.
// - Write-protect low makes the table and marked sectors read-only.
// - Write-protect low enables protection within the assert delay.
// - Releasing the pin drops protection within release delay if never enabled.
// - Enable before or during low period keeps protection after release.
// - A noise filter keeps short glitches on write-protect from acting.
// - Table has 64 bytes, one per sector; FFh protected, 00h not.
package fbp_pkg;
  localparam int CLK_MHZ = 100;

  localparam logic [7:0] OPC_PGM_BUF1 = 8'h82;
  localparam logic [7:0] OPC_PGM_BUF2 = 8'h85;
  localparam logic [7:0] SEQ_BYTE0    = 8'h3D;
  localparam logic [7:0] SEQ_BYTE1    = 8'h2A;
  localparam logic [7:0] SEQ_BYTE2    = 8'h7F;
  localparam logic [7:0] SEQ_ENABLE   = 8'hA9;
  localparam logic [7:0] SEQ_DISABLE  = 8'h9A;
  localparam logic [7:0] TBL_PROT     = 8'hFF;

  localparam int ADDR_W     = 24;
  localparam int PAGE_W     = 13;
  localparam int POS_W      = 10;
  localparam int SECTORS    = 64;
  localparam int SECT_LSB   = 7;
  localparam int STD_PAGE_LSB = 10;
  localparam int BIN_PAGE_LSB = 9;
  localparam int BIN_POS_W    = 9;
  localparam logic [POS_W-1:0] STD_LAST_POS = 10'h20F;
  localparam logic [POS_W-1:0] BIN_LAST_POS = 10'h1FF;
  localparam int BUF_DEPTH  = 528;
  localparam logic [PAGE_W-1:0] SUB0A_PAGES = 13'h0008;
  localparam int SUB0A_HI = 7;
  localparam int SUB0B_HI = 5;

  localparam logic [1:0] ADDR_LAST_IDX = 2'h2;
  localparam logic [2:0] SEQ_LAST_IDX  = 3'h3;
  localparam logic [2:0] SEQ_DONE_IDX  = 3'h4;

  // Least time: round up
  localparam int WP_FILTER_NS  = 50;
  localparam int WP_FILTER_CYC = (WP_FILTER_NS * CLK_MHZ + 999) / 1000;
  // Longest times: round down
  localparam int PROT_ASSERT_DELAY_NS  = 100;
  localparam int PROT_ASSERT_CYC       = PROT_ASSERT_DELAY_NS * CLK_MHZ / 1000;
  localparam int PROT_RELEASE_DELAY_NS = 100;
  localparam int PROT_RELEASE_CYC      = PROT_RELEASE_DELAY_NS * CLK_MHZ / 1000;
  localparam int PAGE_EP_TIME_US = 40;
  localparam int PAGE_EP_CYC     = PAGE_EP_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CMD_OPCODE = 3'b000,
    CMD_ADDR   = 3'b001,
    CMD_DATA   = 3'b010,
    CMD_SEQ    = 3'b011,
    CMD_IGNORE = 3'b100
  } fbp_cmd_type;
endpackage

// File: logic/fbp_spi_rx.sv
`timescale 1ns/1ps
`default_nettype none
module fbp_spi_rx (
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  output logic [7:0]      byte_o,
  output logic            byte_tgl_o
);
  logic [6:0] shift;
  logic [2:0] bit_cnt;
  logic [6:0] next_shift;
  logic [2:0] next_bit_cnt;
  logic       next_tgl;

  always_comb begin
    next_shift   = {shift[5:0], si_i};
    next_bit_cnt = bit_cnt + 3'h1;
    next_tgl     = (bit_cnt == 3'h7) ? ~byte_tgl_o : byte_tgl_o;
  end

  // Deselect clears the frame state; the clock may stop between frames
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      shift      <= 7'h00;
      bit_cnt    <= 3'h0;
      byte_tgl_o <= 1'b0;
    end else begin
      shift      <= next_shift;
      bit_cnt    <= next_bit_cnt;
      byte_tgl_o <= next_tgl;
    end
  end

  // Byte holds for eight link clocks, long enough for the system side
  always_ff @(posedge sck_i) begin
    if (!cs_n_i && bit_cnt == 3'h7) begin
      byte_o <= {shift, si_i};
    end
  end
endmodule // fbp_spi_rx
`default_nettype wire

// File: verification/fbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbp_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b1;
  end

  // Whole frame inside one select, clock parked low between frames
  // Odd start offset keeps the 30 ns clock off the system clock phase
  task automatic send(input logic [7:0] b [8], input int n);
    #107;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        si_o = b[i][k];
        #15 sck_o = 1'b1;
        #15 sck_o = 1'b0;
      end
    end
    // Released line must not look like a held bit
    si_o = ~si_o;
    #45 cs_n_o = 1'b1;
  endtask
endmodule // fbp_host_model
`default_nettype wire

// File: verification/tb_flash_buffered_program_and_protect.sv
`timescale 1ns/1ps
`default_nettype none
module tb_flash_buffered_program_and_protect;
  logic         clk_i;
  logic         rst_i;
  logic         wp_n_i;
  logic         page_bin_i;
  logic [511:0] prot_table_i;
  logic         buf_rd_sel_i;
  logic [9:0]   buf_rd_pos_i;
  wire logic    sck;
  wire logic    cs_n;
  wire logic    si;
  logic [7:0]   buf_rd_data_o;
  logic         pgm_start_o;
  logic [12:0]  pgm_page_o;
  logic         pgm_buf_o;
  logic         pgm_skip_o;
  logic         busy_o;
  logic         ready_busy_o;
  logic         prot_enabled_o;
  logic         prot_by_cmd_o;
  logic         prot_by_pin_o;
  logic         table_writable_o;
  int           bad_count;
  int           n_compared;
  logic [7:0]   fb [8];
  logic         st;
  logic         sk;

  fbp_host_model host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si));

  fbp_flash_ctrl dut (
    .clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .si_i(si),
    .wp_n_i(wp_n_i), .page_bin_i(page_bin_i), .prot_table_i(prot_table_i),
    .buf_rd_sel_i(buf_rd_sel_i), .buf_rd_pos_i(buf_rd_pos_i),
    .buf_rd_data_o(buf_rd_data_o), .pgm_start_o(pgm_start_o),
    .pgm_page_o(pgm_page_o), .pgm_buf_o(pgm_buf_o), .pgm_skip_o(pgm_skip_o),
    .busy_o(busy_o), .ready_busy_o(ready_busy_o),
    .prot_enabled_o(prot_enabled_o), .prot_by_cmd_o(prot_by_cmd_o),
    .prot_by_pin_o(prot_by_pin_o), .table_writable_o(table_writable_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic prog(input logic [7:0] opc, input logic [23:0] a,
                      input logic [7:0] d0, input logic [7:0] d1,
                      input logic [7:0] d2, input int n);
    fb[0] = opc;
    fb[1] = a[23:16];
    fb[2] = a[15:8];
    fb[3] = a[7:0];
    fb[4] = d0;
    fb[5] = d1;
    fb[6] = d2;
    host.send(fb, 4 + n);
  endtask

  task automatic seq4(input logic [7:0] last);
    fb[0] = fbp_pkg::SEQ_BYTE0;
    fb[1] = fbp_pkg::SEQ_BYTE1;
    fb[2] = fbp_pkg::SEQ_BYTE2;
    fb[3] = last;
    host.send(fb, 4);
    step(10);
  endtask

  task automatic wait_pulse();
    st = 1'b0;
    sk = 1'b0;
    for (int i = 0; i < 30 && st !== 1'b1 && sk !== 1'b1; i++) begin
      step(1);
      st = pgm_start_o;
      sk = pgm_skip_o;
    end
  endtask

  // Page cycle must end within the erase-program budget plus 20 cycles
  task automatic wait_idle();
    for (int i = 0; i < fbp_pkg::PAGE_EP_CYC + 20 && busy_o !== 1'b0; i++) step(1);
    if (busy_o !== 1'b0) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic wait_pin(input logic exp);
    for (int i = 0; i < fbp_pkg::PROT_ASSERT_CYC + 2 && prot_by_pin_o !== exp; i++) step(1);
    if (prot_by_pin_o !== exp) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic chk_buf(input logic sel, input logic [9:0] pos, input logic [7:0] exp);
    buf_rd_sel_i = sel;
    buf_rd_pos_i = pos;
    step(1);
    chk_val(buf_rd_data_o, exp);
  endtask

  task automatic s_reset();
    chk_bit(prot_by_cmd_o, 1'b0);
    chk_bit(prot_enabled_o, 1'b0);
    chk_bit(ready_busy_o, 1'b1);
    chk_bit(table_writable_o, 1'b1);
  endtask

  // Start near the buffer end so the third byte wraps
  task automatic s_prog528();
    prog(fbp_pkg::OPC_PGM_BUF1, {1'b0, 13'h0123, 10'h20E}, 8'h11, 8'h22, 8'h33, 3);
    wait_pulse();
    chk_bit(st, 1'b1);
    chk_val(pgm_page_o, 13'h0123);
    chk_bit(pgm_buf_o, 1'b0);
    step(1);
    chk_bit(busy_o, 1'b1);
    chk_bit(ready_busy_o, 1'b0);
    chk_buf(1'b0, 10'h20E, 8'h11);
    chk_buf(1'b0, 10'h20F, 8'h22);
    chk_buf(1'b0, 10'h000, 8'h33);
    wait_idle();
    chk_bit(ready_busy_o, 1'b1);
  endtask

  task automatic s_prog512();
    page_bin_i = 1'b1;
    prog(fbp_pkg::OPC_PGM_BUF2, {2'b00, 13'h1ABC, 9'h1FF}, 8'hAA, 8'hBB, 8'h00, 2);
    wait_pulse();
    chk_bit(st, 1'b1);
    chk_val(pgm_page_o, 13'h1ABC);
    chk_bit(pgm_buf_o, 1'b1);
    chk_buf(1'b1, 10'h1FF, 8'hAA);
    chk_buf(1'b1, 10'h000, 8'hBB);
    page_bin_i = 1'b0;
    wait_idle();
  endtask

  task automatic s_soft();
    seq4(fbp_pkg::SEQ_ENABLE);
    chk_bit(prot_by_cmd_o, 1'b1);
    chk_bit(prot_enabled_o, 1'b1);
    prog(fbp_pkg::OPC_PGM_BUF1, {1'b0, 13'h0285, 10'h000}, 8'h5A, 8'h00, 8'h00, 1);
    wait_pulse();
    chk_bit(sk, 1'b1);
    chk_bit(st, 1'b0);
    chk_bit(busy_o, 1'b0);
    seq4(fbp_pkg::SEQ_DISABLE);
    chk_bit(prot_enabled_o, 1'b0);
  endtask

  task automatic s_pin();
    wp_n_i = 1'b0;
    step(2);
    wp_n_i = 1'b1;
    for (int i = 0; i < 12; i++) begin
      step(1);
      chk_bit(prot_by_pin_o, 1'b0);
    end
    wp_n_i = 1'b0;
    wait_pin(1'b1);
    chk_bit(prot_enabled_o, 1'b1);
    chk_bit(table_writable_o, 1'b0);
    seq4(fbp_pkg::SEQ_DISABLE);
    chk_bit(prot_enabled_o, 1'b1);
    wp_n_i = 1'b1;
    wait_pin(1'b0);
    chk_bit(prot_enabled_o, 1'b0);
    wp_n_i = 1'b0;
    wait_pin(1'b1);
    seq4(fbp_pkg::SEQ_ENABLE);
    wp_n_i = 1'b1;
    wait_pin(1'b0);
    step(12);
    chk_bit(prot_enabled_o, 1'b1);
    seq4(fbp_pkg::SEQ_DISABLE);
    chk_bit(prot_enabled_o, 1'b0);
  endtask

  // Reset in mid-run must drop protection set by command
  task automatic s_rerst();
    seq4(fbp_pkg::SEQ_ENABLE);
    chk_bit(prot_by_cmd_o, 1'b1);
    rst_i = 1'b1;
    step(5);
    rst_i = 1'b0;
    step(5);
    s_reset();
  endtask

  initial begin
    bad_count = 0;
    n_compared = 0;
    rst_i = 1'b1;
    wp_n_i = 1'b1;
    page_bin_i = 1'b0;
    buf_rd_sel_i = 1'b0;
    buf_rd_pos_i = 10'h000;
    prot_table_i = '0;
    prot_table_i[5*8 +: 8] = fbp_pkg::TBL_PROT;
    step(5);
    rst_i = 1'b0;
    step(5);
    s_reset();
    s_prog528();
    s_prog512();
    s_soft();
    s_pin();
    s_rerst();
    conclude();
  end
endmodule // tb_flash_buffered_program_and_protect
`default_nettype wire
